// *** rtl/cidc_dma.v ***
`timescale 1ns/1ps
`default_nettype none
`include "cidc_regs.vh"

////////////////////////////////////////////////////////////////////////////////
// Shift-register FIFO: head entry and flags are flip-flops
module cidc_fifo #(
   parameter WIDTH = 41,
   parameter DEPTH = `CIDC_FIFO_DEPTH
) (
   input  wire             i_core_clk,
   input  wire             i_rst,
   input  wire [WIDTH-1:0] i_in_data,
   input  wire             i_in_valid,
   output wire             o_in_ready,
   output wire [WIDTH-1:0] o_out_data,
   output wire             o_out_valid,
   input  wire             i_out_ready
);
   localparam CW = $clog2(DEPTH + 1);
   reg  [WIDTH-1:0] mem_reg [0:DEPTH];
   reg  [CW-1:0]    cnt_reg;
   reg              full_reg;
   reg              vld_reg;
   wire             push = i_in_valid & ~full_reg;
   wire             pop  = i_out_ready & vld_reg;
   wire [CW-1:0]    cnt_next = cnt_reg + {{(CW-1){1'b0}}, push} - {{(CW-1){1'b0}}, pop};
   genvar g;

   assign o_in_ready  = ~full_reg;
   assign o_out_valid = vld_reg;
   assign o_out_data  = mem_reg[0];

   // Each slot shifts down on pop and takes new data at the tail
   generate
      for (g = 0; g < DEPTH; g = g + 1) begin : g_slot
         always @(posedge i_core_clk or posedge i_rst) begin
            if (i_rst) begin
               mem_reg[g] <= {WIDTH{1'b0}};
            end else if (pop) begin
               if (push && (g == cnt_reg - 1)) begin
                  mem_reg[g] <= i_in_data;
               end else begin
                  mem_reg[g] <= mem_reg[g+1];
               end
            end else if (push && (g == cnt_reg)) begin
               mem_reg[g] <= i_in_data;
            end
         end
      end
   endgenerate

   // Spare slot past the end always reads as zero
   always @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         mem_reg[DEPTH] <= {WIDTH{1'b0}};
      end else begin
         mem_reg[DEPTH] <= {WIDTH{1'b0}};
      end
   end

   // Occupancy and registered flags
   always @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         cnt_reg  <= {CW{1'b0}};
         full_reg <= 1'b0;
         vld_reg  <= 1'b0;
      end else begin
         cnt_reg  <= cnt_next;
         full_reg <= (cnt_next == DEPTH[CW-1:0]);
         vld_reg  <= (cnt_next != {CW{1'b0}});
      end
   end
endmodule

////////////////////////////////////////////////////////////////////////////////
module cidc_dma (
   input  wire        i_core_clk,
   input  wire        i_rst,
   input  wire [7:0]  i_io_addr,
   input  wire        i_io_rd,
   input  wire        i_io_wr,
   input  wire [7:0]  i_io_wdata,
   output reg  [7:0]  o_io_rdata,
   output reg         o_io_rvalid,
   input  wire        i_cpu_reset_output,
   input  wire [3:0]  i_dreq_byte,
   input  wire [3:1]  i_dreq_word,
   output wire [3:0]  o_dack_byte,
   output wire [3:1]  o_dack_word,
   output wire        o_casc_ack,
   output reg  [23:0] o_dma_addr,
   input  wire [15:0] i_per_data,
   input  wire        i_per_valid,
   output reg         o_per_taken,
   output reg         o_tc,
   output reg  [1:0]  o_prog,
   output wire [15:0] o_mem_data,
   output wire [23:0] o_mem_addr,
   output wire        o_mem_wide,
   output wire        o_mem_valid,
   input  wire        i_mem_ready
);
   localparam ST_IDLE = 1'b0;
   localparam ST_ACK  = 1'b1;
   localparam FW      = 41;

   reg  [6:0]  dreq_m_reg;
   reg  [6:0]  dreq_s_reg;
   reg         rst_m_reg;
   reg         rst_s_reg;
   reg  [15:0] base_addr [0:7];
   reg  [15:0] cur_addr  [0:7];
   reg  [15:0] base_cnt  [0:7];
   reg  [15:0] cur_cnt   [0:7];
   reg  [7:0]  mode_reg  [0:7];
   reg  [7:0]  page_reg  [0:15];
   reg  [7:0]  cmd_reg   [0:1];
   reg  [7:0]  mask_reg;
   reg  [7:0]  tc_reg;
   reg  [7:0]  dack_reg;
   reg         ptr_reg;
   reg         state_reg;
   reg  [2:0]  ch_reg;
   reg  [7:0]  rd_next;
   reg  [15:0] rd_word;
   wire        fifo_in_rdy;
   integer     i;
   genvar      g;

   // Pick winner: cascade slot 4 first (lowest byte channel), else 5..7
   function [3:0] cidc_pick;
      input [7:0] e;
      integer k;
      begin
         cidc_pick = 4'h0;
         if (e[4]) begin
            for (k = 3; k >= 0; k = k - 1) begin
               if (e[k]) cidc_pick = {1'b1, k[2:0]};
            end
         end else begin
            for (k = 7; k >= 5; k = k - 1) begin
               if (e[k]) cidc_pick = {1'b1, k[2:0]};
            end
         end
      end
   endfunction

   // Page register index for a channel
   function [3:0] cidc_pg;
      input [2:0] ch;
      begin
         case (ch)
            3'd0:    cidc_pg = `CIDC_PG_CH0;
            3'd1:    cidc_pg = `CIDC_PG_CH1;
            3'd2:    cidc_pg = `CIDC_PG_CH2;
            3'd3:    cidc_pg = `CIDC_PG_CH3;
            3'd5:    cidc_pg = `CIDC_PG_CH5;
            3'd6:    cidc_pg = `CIDC_PG_CH6;
            3'd7:    cidc_pg = `CIDC_PG_CH7;
            default: cidc_pg = `CIDC_PG_OTHER;
         endcase
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // I/O decode
   wire       acc      = i_io_rd | i_io_wr;
   wire [3:0] off      = i_io_addr[3:0];
   wire       sel_byte = (i_io_addr[7:4] == `CIDC_BYTE_HI);
   wire       sel_word = (i_io_addr[7:4] == `CIDC_WORD_HI);
   wire       sel_page = (i_io_addr[7:4] == `CIDC_PAGE_HI);
   wire       sel_ctl  = sel_byte | sel_word;
   wire       ctl      = sel_word;
   wire [2:0] ch_sel   = {sel_word, off[2:1]};
   wire       sel_pair = sel_ctl & ~off[3];

   ////////////////////////////////////////////////////////////////////////////
   // Request view: bit 4 is the cascade request from the byte controller
   wire       casc_pend = |dreq_s_reg[3:0];
   wire [7:0] req_v     = {dreq_s_reg[6:4], casc_pend, dreq_s_reg[3:0]};
   wire [1:0] dis       = {cmd_reg[1][`CIDC_CMD_DIS], cmd_reg[0][`CIDC_CMD_DIS]};
   wire [7:0] elig;

   // Eligible: requested, unmasked, controller enabled, not programming
   generate
      for (g = 0; g < 8; g = g + 1) begin : g_elig
         if (g < 4) begin : g_b
            assign elig[g] = req_v[g] & ~mask_reg[g] & ~o_prog[0] & ~dis[0];
         end else if (g == 4) begin : g_c
            assign elig[g] = (|elig[3:0]) & ~mask_reg[4] & ~o_prog[1] & ~dis[1];
         end else begin : g_w
            assign elig[g] = req_v[g] & ~mask_reg[g] & ~o_prog[1] & ~dis[1];
         end
      end
   endgenerate

   wire [3:0] win    = cidc_pick(elig);
   wire [2:0] win_ch = win[2:0];
   wire [7:0] win_pg = page_reg[cidc_pg(win_ch)];
   wire       ahold  = cmd_reg[0][`CIDC_CMD_AHOLD];
   wire       push   = (state_reg == ST_ACK) & req_v[ch_reg] & i_per_valid & fifo_in_rdy;
   wire       ch_dec = mode_reg[ch_reg][`CIDC_MODE_DEC];
   wire       ch_aut = mode_reg[ch_reg][`CIDC_MODE_AUTO];

   assign o_dack_byte = dack_reg[3:0];
   assign o_dack_word = dack_reg[7:5];
   assign o_casc_ack  = dack_reg[4];

   ////////////////////////////////////////////////////////////////////////////
   // Two-flop synchronisers for request pins and the CPU reset output
   always @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         dreq_m_reg <= 7'h00;
         dreq_s_reg <= 7'h00;
         rst_m_reg  <= 1'b0;
         rst_s_reg  <= 1'b0;
      end else begin
         dreq_m_reg <= {i_dreq_word, i_dreq_byte};
         dreq_s_reg <= dreq_m_reg;
         rst_m_reg  <= i_cpu_reset_output;
         rst_s_reg  <= rst_m_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register file and transfer engine; engine updates come last so set wins
   always @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         for (i = 0; i < 8; i = i + 1) begin
            base_addr[i] <= `CIDC_WORD_RST;
            cur_addr[i]  <= `CIDC_WORD_RST;
            base_cnt[i]  <= `CIDC_WORD_RST;
            cur_cnt[i]   <= `CIDC_WORD_RST;
            mode_reg[i]  <= `CIDC_MODE_RST;
         end
         for (i = 0; i < 16; i = i + 1) begin
            page_reg[i] <= `CIDC_PAGE_RST;
         end
         cmd_reg[0]  <= `CIDC_CMD_RST;
         cmd_reg[1]  <= `CIDC_CMD_RST;
         mask_reg    <= `CIDC_MASK_RST;
         tc_reg      <= 8'h00;
         ptr_reg     <= 1'b0;
         o_prog      <= 2'b00;
         state_reg   <= ST_IDLE;
         ch_reg      <= 3'h0;
         dack_reg    <= 8'h00;
         o_dma_addr  <= 24'h000000;
         o_per_taken <= 1'b0;
         o_tc        <= 1'b0;
      end else begin
         o_per_taken <= 1'b0;
         o_tc        <= 1'b0;
         o_prog      <= {acc & sel_word, acc & sel_byte};
         if (rst_s_reg) begin
            ptr_reg <= 1'b0;
            tc_reg  <= 8'h00;
         end else if (acc & sel_pair) begin
            ptr_reg <= ~ptr_reg;
            if (i_io_wr & ~off[0]) begin
               if (ptr_reg) begin
                  base_addr[ch_sel][15:8] <= i_io_wdata;
                  cur_addr[ch_sel][15:8]  <= i_io_wdata;
               end else begin
                  base_addr[ch_sel][7:0] <= i_io_wdata;
                  cur_addr[ch_sel][7:0]  <= i_io_wdata;
               end
            end else if (i_io_wr) begin
               if (ptr_reg) begin
                  base_cnt[ch_sel][15:8] <= i_io_wdata;
                  cur_cnt[ch_sel][15:8]  <= i_io_wdata;
               end else begin
                  base_cnt[ch_sel][7:0] <= i_io_wdata;
                  cur_cnt[ch_sel][7:0]  <= i_io_wdata;
               end
            end
         end else if (acc & sel_ctl) begin
            if (off == `CIDC_OFF_STATCMD) begin
               if (i_io_wr) begin
                  cmd_reg[ctl] <= i_io_wdata;
               end else begin
                  tc_reg[{ctl, 2'b00} +: 4] <= 4'h0;
               end
            end else if (off == `CIDC_OFF_FFCTL) begin
               ptr_reg <= i_io_rd;
            end else if (i_io_wr && off == `CIDC_OFF_SMASK) begin
               mask_reg[{ctl, i_io_wdata[1:0]}] <= i_io_wdata[2];
            end else if (i_io_wr && off == `CIDC_OFF_MODE) begin
               mode_reg[{ctl, i_io_wdata[1:0]}] <= i_io_wdata;
            end else if (i_io_wr && off == `CIDC_OFF_MCLR) begin
               cmd_reg[ctl]               <= `CIDC_CMD_RST;
               tc_reg[{ctl, 2'b00} +: 4]  <= 4'h0;
               mask_reg[{ctl, 2'b00} +: 4] <= 4'hF;
               ptr_reg                    <= 1'b0;
            end else if (i_io_wr && off == `CIDC_OFF_CLRMASK) begin
               mask_reg[{ctl, 2'b00} +: 4] <= 4'h0;
            end else if (i_io_wr && off == `CIDC_OFF_ALLMASK) begin
               mask_reg[{ctl, 2'b00} +: 4] <= i_io_wdata[3:0];
            end
         end else if (i_io_wr & sel_page) begin
            page_reg[off] <= i_io_wdata;
         end
         // Transfer engine
         case (state_reg)
            ST_IDLE: begin
               if (win[3]) begin
                  state_reg <= ST_ACK;
                  ch_reg    <= win_ch;
                  dack_reg  <= (8'h01 << win_ch) | {3'b000, ~win_ch[2], 4'h0};
                  if (win_ch[2]) begin
                     o_dma_addr <= {win_pg[7:1], cur_addr[win_ch], 1'b0};
                  end else begin
                     o_dma_addr <= {win_pg[7:1], win_pg[0], cur_addr[win_ch]};
                  end
               end
            end
            ST_ACK: begin
               if (!req_v[ch_reg]) begin
                  state_reg <= ST_IDLE;
                  dack_reg  <= 8'h00;
               end else if (push) begin
                  state_reg   <= ST_IDLE;
                  dack_reg    <= 8'h00;
                  o_per_taken <= 1'b1;
                  if (!(ch_reg == 3'd0 && ahold)) begin
                     cur_addr[ch_reg] <= ch_dec ? cur_addr[ch_reg] - `CIDC_CNT_STEP
                                                : cur_addr[ch_reg] + `CIDC_CNT_STEP;
                  end
                  cur_cnt[ch_reg] <= cur_cnt[ch_reg] - `CIDC_CNT_STEP;
                  if (cur_cnt[ch_reg] == `CIDC_CNT_LAST) begin
                     tc_reg[ch_reg] <= 1'b1;
                     o_tc           <= 1'b1;
                     if (ch_aut) begin
                        cur_addr[ch_reg] <= base_addr[ch_reg];
                        cur_cnt[ch_reg]  <= base_cnt[ch_reg];
                     end else begin
                        mask_reg[ch_reg] <= 1'b1;
                     end
                  end
               end
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read data selection
   always @* begin
      rd_next = 8'h00;
      rd_word = off[0] ? cur_cnt[ch_sel] : cur_addr[ch_sel];
      if (sel_pair) begin
         rd_next = ptr_reg ? rd_word[15:8] : rd_word[7:0];
      end else if (sel_ctl && off == `CIDC_OFF_STATCMD) begin
         rd_next = {req_v[{ctl, 2'b00} +: 4], tc_reg[{ctl, 2'b00} +: 4]};
      end else if (sel_page) begin
         rd_next = page_reg[off];
      end
   end

   // Registered read answer, one cycle after the strobe
   always @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         o_io_rdata  <= 8'h00;
         o_io_rvalid <= 1'b0;
      end else begin
         o_io_rvalid <= i_io_rd;
         if (i_io_rd) begin
            o_io_rdata <= rd_next;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Transferred words queue toward memory; a full queue stalls the engine
   cidc_fifo #(
      .WIDTH (FW),
      .DEPTH (`CIDC_FIFO_DEPTH)
   ) u_fifo (
      .i_core_clk  (i_core_clk),
      .i_rst       (i_rst),
      .i_in_data   ({ch_reg[2], o_dma_addr, ch_reg[2] ? i_per_data : {8'h00, i_per_data[7:0]}}),
      .i_in_valid  (push),
      .o_in_ready  (fifo_in_rdy),
      .o_out_data  ({o_mem_wide, o_mem_addr, o_mem_data}),
      .o_out_valid (o_mem_valid),
      .i_out_ready (i_mem_ready)
   );
endmodule
`default_nettype wire

// *** shared/cidc_regs.vh ***
`ifndef CIDC_REGS_VH
`define CIDC_REGS_VH
// I/O decode on address bits 7:4
`define CIDC_BYTE_HI      4'h0
`define CIDC_WORD_HI      4'hC
`define CIDC_PAGE_HI      4'h8
// Controller register offsets (0..7 are address/count pairs)
`define CIDC_OFF_STATCMD  4'h8
`define CIDC_OFF_SMASK    4'hA
`define CIDC_OFF_MODE     4'hB
`define CIDC_OFF_FFCTL    4'hC
`define CIDC_OFF_MCLR     4'hD
`define CIDC_OFF_CLRMASK  4'hE
`define CIDC_OFF_ALLMASK  4'hF
// Field positions
`define CIDC_CMD_AHOLD    1
`define CIDC_CMD_DIS      2
`define CIDC_MODE_AUTO    4
`define CIDC_MODE_DEC     5
// Reset values
`define CIDC_MASK_RST     8'hFF
`define CIDC_CMD_RST      8'h00
`define CIDC_PAGE_RST     8'h00
`define CIDC_WORD_RST     16'h0000
`define CIDC_MODE_RST     8'h00
// Count value that produces terminal count on the next step
`define CIDC_CNT_LAST     16'h0000
`define CIDC_CNT_STEP     16'h0001
// Page register index per channel
`define CIDC_PG_CH0       4'h7
`define CIDC_PG_CH1       4'h3
`define CIDC_PG_CH2       4'h1
`define CIDC_PG_CH3       4'h2
`define CIDC_PG_CH5       4'hB
`define CIDC_PG_CH6       4'h9
`define CIDC_PG_CH7       4'hA
`define CIDC_PG_OTHER     4'hF
// Output FIFO shape
`define CIDC_FIFO_DEPTH   8
`endif

// *** sim/cidc_dma_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "cidc_regs.vh"
////////////////////////////////////////////////////////////////////////////////
// Port-level checks of the cascaded controller
module cidc_dma_asserts (
   input wire logic        i_core_clk,
   input wire logic        i_rst,
   input wire logic [7:0]  i_io_addr,
   input wire logic        i_io_rd,
   input wire logic        i_io_wr,
   input wire logic [7:0]  o_io_rdata,
   input wire logic        o_io_rvalid,
   input wire logic [3:0]  o_dack_byte,
   input wire logic [3:1]  o_dack_word,
   input wire logic        o_casc_ack,
   input wire logic [23:0] o_dma_addr,
   input wire logic        i_per_valid,
   input wire logic        o_per_taken,
   input wire logic        o_tc,
   input wire logic [1:0]  o_prog,
   input wire logic [23:0] o_mem_addr,
   input wire logic        o_mem_valid,
   input wire logic        i_mem_ready
);
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_rst);
   // Read answer comes exactly one cycle after the strobe
   property p_rd_ans; o_io_rvalid == $past(i_io_rd); endproperty
   a_rd_ans: assert property (p_rd_ans) else $error("read answer misplaced");
   property p_unmapped;
      i_io_rd && !(i_io_addr[7:4] inside {`CIDC_BYTE_HI, `CIDC_WORD_HI, `CIDC_PAGE_HI})
      |=> o_io_rdata == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_prog_b;
      o_prog[0] == $past((i_io_rd || i_io_wr) && i_io_addr[7:4] == `CIDC_BYTE_HI);
   endproperty
   a_prog_b: assert property (p_prog_b) else $error("byte program phase wrong");
   property p_prog_w;
      o_prog[1] == $past((i_io_rd || i_io_wr) && i_io_addr[7:4] == `CIDC_WORD_HI);
   endproperty
   a_prog_w: assert property (p_prog_w) else $error("word program phase wrong");
   // Grant shape and transfer addressing
   property p_casc; o_casc_ack == (|o_dack_byte); endproperty
   a_casc: assert property (p_casc) else $error("cascade ack mismatch");
   property p_one; $onehot0({o_dack_byte, o_dack_word}); endproperty
   a_one: assert property (p_one) else $error("several grants at once");
   property p_a0; |o_dack_word |-> o_dma_addr[0] == 1'b0; endproperty
   a_a0: assert property (p_a0) else $error("word address line 0 set");
   property p_taken;
      o_per_taken |-> $past(i_per_valid && |{o_dack_byte, o_dack_word});
   endproperty
   a_taken: assert property (p_taken) else $error("data taken without grant");
   property p_tc; o_tc |-> o_per_taken; endproperty
   a_tc: assert property (p_tc) else $error("terminal count without transfer");
   property p_hold; o_mem_valid && !i_mem_ready |=> o_mem_valid && $stable(o_mem_addr); endproperty
   a_hold: assert property (p_hold) else $error("buffer head moved while stalled");
endmodule
`default_nettype wire

// *** sim/cidc_per_model.sv ***
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// ISA peripherals: raise requests, answer grants with data
module cidc_per_model (
   input  wire logic        i_core_clk,
   input  wire logic        i_rst,
   input  wire logic [6:0]  i_want,
   input  wire logic        i_slow,
   input  wire logic [3:0]  i_dack_byte,
   input  wire logic [3:1]  i_dack_word,
   input  wire logic [23:0] i_dma_addr,
   input  wire logic        i_per_taken,
   output logic      [3:0]  o_dreq_byte,
   output logic      [3:1]  o_dreq_word,
   output logic      [15:0] o_per_data,
   output logic             o_per_valid
);
   logic [1:0] wait_reg;
   // Requests follow the wanted channels; data offered after the grant
   always @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         o_dreq_byte <= 4'h0;
         o_dreq_word <= 3'h0;
         o_per_data  <= 16'h0000;
         o_per_valid <= 1'b0;
         wait_reg    <= 2'h0;
      end else begin
         o_dreq_byte <= i_want[3:0];
         o_dreq_word <= i_want[6:4];
         if (!(|{i_dack_byte, i_dack_word}))
            wait_reg <= i_slow ? 2'h3 : 2'h0;
         else if (wait_reg != 2'h0)
            wait_reg <= wait_reg - 2'h1;
         if (o_per_valid) begin
            // Withdraw data once taken or once the grant is cancelled
            if (i_per_taken || !(|{i_dack_byte, i_dack_word}))
               o_per_valid <= 1'b0;
         end else if (|{i_dack_byte, i_dack_word} && wait_reg == 2'h0) begin
            o_per_valid <= 1'b1;
            o_per_data  <= i_dma_addr[15:0] ^ 16'h5A5A;
         end else
            o_per_data <= ~o_per_data; // Released bus inverts its value every cycle while no data is offered
      end
   end
endmodule
`default_nettype wire

// *** sim/cidc_dma_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Bench top: clock, reset, device, peripheral model and tests
module cidc_dma_tb_top;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [7:0]  io_addr = 8'h00;
   logic        io_rd = 1'b0;
   logic        io_wr = 1'b0;
   logic [7:0]  io_wdata = 8'h00;
   logic        cpu_rst = 1'b0;
   logic        mem_ready = 1'b1;
   logic        slow = 1'b0;
   logic [6:0]  want = 7'h00;
   wire  [7:0]  io_rdata;
   wire         io_rvalid, casc_ack, per_valid, per_taken, tc, mem_wide, mem_valid;
   wire  [3:0]  dreq_byte, dack_byte;
   wire  [3:1]  dreq_word, dack_word;
   wire  [23:0] dma_addr, mem_addr;
   wire  [15:0] per_data, mem_data;
   wire  [1:0]  prog;
   wire  [15:0] pop_data = mem_wide ? mem_data : {8'h00, mem_data[7:0]};
   int          err_count = 0;
   int          samples_checked = 0;
   int          taken_cnt = 0;
   int          tc_cnt = 0;
   logic [40:0] exp_q[$];

   always #4 clk = ~clk;

   cidc_dma cidc_dma_inst (.i_core_clk(clk), .i_rst(rst), .i_io_addr(io_addr),
      .i_io_rd(io_rd), .i_io_wr(io_wr), .i_io_wdata(io_wdata), .o_io_rdata(io_rdata),
      .o_io_rvalid(io_rvalid), .i_cpu_reset_output(cpu_rst), .i_dreq_byte(dreq_byte),
      .i_dreq_word(dreq_word), .o_dack_byte(dack_byte), .o_dack_word(dack_word),
      .o_casc_ack(casc_ack), .o_dma_addr(dma_addr), .i_per_data(per_data),
      .i_per_valid(per_valid), .o_per_taken(per_taken), .o_tc(tc), .o_prog(prog),
      .o_mem_data(mem_data), .o_mem_addr(mem_addr), .o_mem_wide(mem_wide),
      .o_mem_valid(mem_valid), .i_mem_ready(mem_ready));

   cidc_per_model cidc_per_model_inst (.i_core_clk(clk), .i_rst(rst), .i_want(want),
      .i_slow(slow), .i_dack_byte(dack_byte), .i_dack_word(dack_word), .i_dma_addr(dma_addr),
      .i_per_taken(per_taken), .o_dreq_byte(dreq_byte), .o_dreq_word(dreq_word),
      .o_per_data(per_data), .o_per_valid(per_valid));

   ////////////////////////////////////////////////////////////////////////////////
   // Comparisons, bus cycles and expectations
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %0t value %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_pop(input logic [40:0] got, input logic [40:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %0t buffer entry %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      io_addr <= a;
      io_wdata <= d;
      io_wr <= 1'b1;
      @(posedge clk);
      io_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      io_addr <= a;
      io_rd <= 1'b1;
      @(posedge clk);
      io_rd <= 1'b0;
      @(negedge clk);
      chk8(io_rdata, exp);
      @(posedge clk);
   endtask
   task automatic exp_run(input logic w, input logic [7:0] pg, input logic [15:0] a0,
                          input logic dec, input logic hold, input int n);
      logic [15:0] a;
      logic [23:0] fa;
      a = a0;
      for (int k = 0; k < n; k++) begin
         fa = w ? {pg[7:1], a, 1'b0} : {pg, a};
         exp_q.push_back({w, fa, w ? fa[15:0] ^ 16'h5A5A : {8'h00, fa[7:0] ^ 8'h5A}});
         if (!hold)
            a = dec ? a - 16'h0001 : a + 16'h0001;
      end
   endtask
   task automatic drain();
      for (int i = 0; i < 600 && exp_q.size() != 0; i++) @(posedge clk);
      repeat (20) @(posedge clk);
      chk8(8'(exp_q.size()), 8'h00);
   endtask
   task automatic give_verdict();
      $display("checks %0d errors %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Buffer drain side: every pop is matched against the expected queue
   always @(posedge clk) begin
      if (!rst && mem_valid && mem_ready)
         chk_pop({mem_wide, mem_addr, pop_data}, exp_q.size() ? exp_q.pop_front() : 41'h0);
      if (per_taken)
         taken_cnt++;
      if (tc)
         tc_cnt++;
   end

   initial begin
      #200000;
      err_count++;
      give_verdict();
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Test sequence
   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      // Reset values, decode and the byte pointer
      rd(8'h00, 8'h00);
      rd(8'h00, 8'h00);
      rd(8'h87, 8'h00);
      rd(8'hC8, 8'h00);
      wr(8'h61, 8'hFF);
      rd(8'h61, 8'h00);
      wr(8'h02, 8'h78);
      wr(8'h02, 8'h56);
      wr(8'h03, 8'h02);
      wr(8'h03, 8'h00);
      rd(8'h02, 8'h78);
      rd(8'h02, 8'h56);
      rd(8'h03, 8'h02);
      rd(8'h03, 8'h00);
      rd(8'hC4, 8'h00);
      rd(8'h02, 8'h56);
      rd(8'h0C, 8'h00);
      rd(8'h02, 8'h56);
      rd(8'h0C, 8'h00);
      wr(8'h0C, 8'h00);
      rd(8'h02, 8'h78);
      wr(8'h0D, 8'h00);
      rd(8'h02, 8'h78);
      cpu_rst <= 1'b1;
      repeat (4) @(posedge clk);
      cpu_rst <= 1'b0;
      repeat (4) @(posedge clk);
      rd(8'h02, 8'h78);
      rd(8'h02, 8'h56);
      // Byte channel 3 through a stalled buffer, masked on terminal count
      wr(8'h82, 8'h12);
      wr(8'h06, 8'hFE);
      wr(8'h06, 8'h00);
      wr(8'h07, 8'h09);
      wr(8'h07, 8'h00);
      wr(8'h0B, 8'h03);
      wr(8'hCA, 8'h00);
      wr(8'h0E, 8'h00);
      mem_ready <= 1'b0;
      exp_run(1'b0, 8'h12, 16'h00FE, 1'b0, 1'b0, 10);
      want <= 7'h08;
      repeat (150) @(posedge clk);
      chk8(8'(taken_cnt), 8'h08);
      chk8({4'h0, dack_byte}, 8'h08);
      mem_ready <= 1'b1;
      drain();
      chk8(8'(tc_cnt), 8'h01);
      rd(8'h08, 8'h88);
      rd(8'h08, 8'h80);
      want <= 7'h00;
      repeat (5) @(posedge clk);
      rd(8'h08, 8'h00);
      // Word channel 5, decrementing with autoinit and a slow peripheral
      slow <= 1'b1;
      wr(8'h8B, 8'h34);
      wr(8'hC2, 8'h00);
      wr(8'hC2, 8'h10);
      wr(8'hC3, 8'h01);
      wr(8'hC3, 8'h00);
      wr(8'hCB, 8'h31);
      wr(8'hCE, 8'h00);
      exp_run(1'b1, 8'h34, 16'h1000, 1'b1, 1'b0, 2);
      exp_run(1'b1, 8'h34, 16'h1000, 1'b1, 1'b0, 1);
      want <= 7'h10;
      for (int i = 0; i < 300 && taken_cnt < 13; i++) @(posedge clk);
      want <= 7'h00;
      drain();
      chk8(8'(tc_cnt), 8'h02);
      rd(8'hC2, 8'hFF);
      rd(8'hC2, 8'h0F);
      rd(8'hC3, 8'h00);
      rd(8'hC3, 8'h00);
      // Byte channel 0 with address hold
      slow <= 1'b0;
      wr(8'h0A, 8'h04);
      wr(8'h08, 8'h02);
      wr(8'h87, 8'h56);
      wr(8'h00, 8'h40);
      wr(8'h00, 8'h00);
      wr(8'h01, 8'h01);
      wr(8'h01, 8'h00);
      wr(8'h0B, 8'h00);
      wr(8'h0A, 8'h00);
      exp_run(1'b0, 8'h56, 16'h0040, 1'b0, 1'b1, 2);
      want <= 7'h01;
      drain();
      want <= 7'h00;
      chk8(8'(tc_cnt), 8'h03);
      give_verdict();
   end
endmodule

bind cidc_dma cidc_dma_asserts cidc_dma_asserts_inst (.i_core_clk, .i_rst, .i_io_addr,
   .i_io_rd, .i_io_wr, .o_io_rdata, .o_io_rvalid, .o_dack_byte, .o_dack_word, .o_casc_ack,
   .o_dma_addr, .i_per_valid, .o_per_taken, .o_tc, .o_prog, .o_mem_addr, .o_mem_valid,
   .i_mem_ready);
`default_nettype wire
